// *** cdp_clk_pwr.sv ***
// Clock divider, alignment, duty-cycle stabilizer and power-state control
`timescale 1ns/10ps
//
// Overview of operation
// - Divide sample clock by one to eight
// - Alignment pulse input can realign divider
// - Two bits pick every-pulse or first-after-write
// - Accepted pulse returns divider to initial state
// - Shared pulse aligns sampling across converters
// - Stabilizer regenerates falling edge, half period
// - Stabilizer loop idle for too-slow clocks
// - Power-down by register setting or pin
// - Output drivers high impedance while powered down
// - Pin low returns device to normal when the register requests run
// - Power-down stops reference, buffer, bias, clock
// - Register standby keeps reference circuitry powered
// - Sense pin level selects internal or external
// - Sample taken on internal clock rising edge
module cdp_clk_pwr
    import cdp_pkg::*;
#(
    parameter int unsigned PER_W      = 8,   // Period counter width
    parameter int unsigned SLOW_LIMIT = 200  // Longest period the loop serves
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              sample_clk_in,   // Incoming sample clock
    input  wire logic              sync_in,         // Divider alignment pin
    input  wire logic              power_down_pin,  // High requests power-down
    input  wire logic              sense_at_supply, // Sense at analog_supply
    input  wire logic              reg_wr_en,       // Register write strobe
    input  wire logic              reg_rd_en,       // Register read strobe
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata_q,     // Read data
    output logic                   int_clk_q,       // Internal sample clock
    output logic                   sample_q,        // Sample strobe
    output logic                   out_drv_oe_q,    // Output drivers enabled
    output logic                   ref_on_q,        // Reference powered
    output logic                   ref_buf_on_q,    // Reference buffer powered
    output logic                   bias_on_q,       // Bias networks powered
    output logic                   ref_internal_q,  // Internal 1.0 V in use
    output logic                   dcs_locked_q     // Stabilizer locked
);
    // Elaboration check: the period counter must hold the slow limit
    if (PER_W < 4 || PER_W > 12 || SLOW_LIMIT >= (1 << PER_W) ||
        SLOW_LIMIT < 2) begin : g_bad_param
        $error("cdp_clk_pwr: bad period counter parameters");
    end

    // Pin synchronisers: two flops each; edge history flops for the sample clock and alignment pin only
    logic [1:0] sclk_sync_q;
    logic [1:0] sync_sync_q;
    logic [1:0] pd_sync_q;
    logic [1:0] sense_sync_q;
    logic       sclk_prev_q;
    logic       sync_prev_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_sync_q  <= 2'h0;
            sync_sync_q  <= 2'h0;
            pd_sync_q    <= 2'h0;
            sense_sync_q <= 2'h0;
            sclk_prev_q  <= 1'b0;
            sync_prev_q  <= 1'b0;
        end else begin
            sclk_sync_q  <= {sclk_sync_q[0], sample_clk_in};
            sync_sync_q  <= {sync_sync_q[0], sync_in};
            pd_sync_q    <= {pd_sync_q[0], power_down_pin};
            sense_sync_q <= {sense_sync_q[0], sense_at_supply};
            sclk_prev_q  <= sclk_sync_q[1];
            sync_prev_q  <= sync_sync_q[1];
        end
    end

    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic sync_rise;
    assign sclk_lvl  = sclk_sync_q[1];
    assign sclk_rise = sclk_lvl && !sclk_prev_q;
    assign sclk_fall = !sclk_lvl && sclk_prev_q;
    assign sync_rise = sync_sync_q[1] && !sync_prev_q;

    // Register file state
    logic [7:0] sync_ctrl_q, sync_ctrl_d;
    logic [7:0] div_ratio_q, div_ratio_d;
    logic [7:0] pwr_mode_q,  pwr_mode_d;
    logic [7:0] dcs_ctrl_q,  dcs_ctrl_d;
    logic       armed_q,     armed_d;     // One-shot alignment armed
    logic [7:0] rdata_d;
    logic       sync_accept;
    logic       wr_sync;

    logic [2:0] status;
    cdp_pwr_state_t ps_q, ps_d;

    // Alignment acceptance by mode bits
    always_comb begin
        wr_sync     = reg_wr_en && (reg_addr == REG_SYNC_CTRL);
        sync_accept = 1'b0;
        if (sync_rise && sync_ctrl_q[SYNC_EN_BIT]) begin
            // Every pulse, or only the first after the last write
            sync_accept = !sync_ctrl_q[SYNC_ONCE_BIT] || armed_q;
        end
    end

    // Register writes, arming and read mux
    always_comb begin
        sync_ctrl_d = sync_ctrl_q;
        div_ratio_d = div_ratio_q;
        pwr_mode_d  = pwr_mode_q;
        dcs_ctrl_d  = dcs_ctrl_q;
        armed_d     = armed_q;
        rdata_d     = reg_rdata_q;
        // A used one-shot disarms
        if (sync_accept && sync_ctrl_q[SYNC_ONCE_BIT]) begin
            armed_d = 1'b0;
        end
        // A write arms again; wins over a same-cycle disarm
        if (wr_sync) begin
            armed_d = 1'b1;
        end
        if (reg_wr_en) begin
            unique case (reg_addr)
                REG_SYNC_CTRL: sync_ctrl_d = reg_wdata;
                REG_DIV_RATIO: div_ratio_d = reg_wdata;
                REG_PWR_MODE:  pwr_mode_d  = reg_wdata;
                REG_DCS_CTRL:  dcs_ctrl_d  = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd_en) begin
            unique case (reg_addr)
                REG_SYNC_CTRL: rdata_d = sync_ctrl_q;
                REG_DIV_RATIO: rdata_d = div_ratio_q;
                REG_PWR_MODE:  rdata_d = pwr_mode_q;
                REG_DCS_CTRL:  rdata_d = dcs_ctrl_q;
                REG_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[ST_OFF_BIT]   = status[0];
                    rdata_d[ST_STBY_BIT]  = status[1];
                    rdata_d[ST_LOCK_BIT]  = status[2];
                    rdata_d[ST_REFI_BIT]  = ref_internal_q;
                    rdata_d[ST_ARMED_BIT] = armed_q;
                end
                // Unmapped addresses read as zero
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_ctrl_q <= SYNC_CTRL_RST;
            div_ratio_q <= DIV_RATIO_RST;
            pwr_mode_q  <= PWR_MODE_RST;
            dcs_ctrl_q  <= DCS_CTRL_RST;
            armed_q     <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            sync_ctrl_q <= sync_ctrl_d;
            div_ratio_q <= div_ratio_d;
            pwr_mode_q  <= pwr_mode_d;
            dcs_ctrl_q  <= dcs_ctrl_d;
            armed_q     <= armed_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // Power state: pin or register enters off, register alone standby
    always_comb begin
        ps_d = PS_RUN; // Pin low and no request: normal
        if (pd_sync_q[1] ||
            pwr_mode_q[PWR_LSB +: PWR_W] == PWR_REQ_OFF) begin
            ps_d = PS_OFF;
        end else if (pwr_mode_q[PWR_LSB +: PWR_W] == PWR_REQ_STBY) begin
            ps_d = PS_STBY;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ps_q <= PS_RUN;
        end else begin
            ps_q <= ps_d;
        end
    end

    logic running;
    assign running = (ps_q == PS_RUN);

    // Divider counter; alignment pulse forces initial state
    logic             div_start;
    logic [DIV_W-1:0] div_cnt;

    cdp_div_cnt #(
        .W (DIV_W)
    ) u_div (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .advance  (sclk_rise && running),
        .realign  (sync_accept),
        .ratio_m1 (div_ratio_q[DIV_LSB +: DIV_W]),
        .start    (div_start),
        .cnt_q    (div_cnt)
    );

    // Stabilizer: measure input period, hold half the divided period
    logic [PER_W-1:0]   per_cnt_q,  per_cnt_d;  // Cycles since last rise
    logic [PER_W-1:0]   per_q,      per_d;      // Last measured period
    logic [PER_W+2:0]   half_q,     half_d;     // Half divided period
    logic [PER_W+2:0]   hi_cnt_q,   hi_cnt_d;   // Cycles since divided rise
    logic [5:0]         lock_cnt_q, lock_cnt_d; // Stable cycles
    logic               locked_d;
    logic               loop_ok;
    logic               int_clk_d;

    always_comb begin
        per_cnt_d  = per_cnt_q;
        per_d      = per_q;
        lock_cnt_d = lock_cnt_q;
        // Period counter saturates when the clock is slow or stopped
        if (sclk_rise) begin
            per_cnt_d = PER_W'(1);
            per_d     = per_cnt_q;
        end else if (per_cnt_q != '1) begin
            per_cnt_d = per_cnt_q + PER_W'(1);
        end
        // Loop only serves clocks fast enough to be tracked
        loop_ok = (per_q <= PER_W'(SLOW_LIMIT)) &&
                  (per_cnt_q <= PER_W'(SLOW_LIMIT));
        // Any period change restarts the relock wait
        if (sclk_rise && per_cnt_q != per_q) begin
            lock_cnt_d = 6'h00;
        end else if (lock_cnt_q != 6'(DCS_RELOCK_CYC)) begin
            lock_cnt_d = lock_cnt_q + 6'h01;
        end
        locked_d = loop_ok && running && dcs_ctrl_q[DCS_EN_BIT] &&
                   (lock_cnt_d == 6'(DCS_RELOCK_CYC));
        half_d = ({3'h0, per_q} *
                  ({{PER_W{1'b0}}, div_ratio_q[DIV_LSB +: DIV_W]} +
                   (PER_W+3)'(1))) >> 1;
    end

    // Internal clock edges
    always_comb begin
        hi_cnt_d  = hi_cnt_q;
        int_clk_d = int_clk_q;
        if (!running) begin
            int_clk_d = 1'b0; // Clock stopped off and in standby
            hi_cnt_d  = '0;
        end else if (div_start) begin
            int_clk_d = 1'b1; // Rising edge is the input's own
            hi_cnt_d  = (PER_W+3)'(1);
        end else if (int_clk_q) begin
            hi_cnt_d = hi_cnt_q + (PER_W+3)'(1);
            if (dcs_locked_q) begin
                // Regenerated falling edge at half the period
                if (hi_cnt_q >= half_q) begin
                    int_clk_d = 1'b0;
                end
            end else if (sclk_fall && div_cnt == '0) begin
                // Loop idle: the input's own falling edge ends the high
                int_clk_d = 1'b0;
            end else if (sclk_fall &&
                         div_ratio_q[DIV_LSB +: DIV_W] == '0) begin
                int_clk_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            per_cnt_q    <= '0;
            per_q        <= '1;
            half_q       <= '0;
            hi_cnt_q     <= '0;
            lock_cnt_q   <= 6'h00;
            dcs_locked_q <= 1'b0;
            int_clk_q    <= 1'b0;
        end else begin
            per_cnt_q    <= per_cnt_d;
            per_q        <= per_d;
            half_q       <= half_d;
            hi_cnt_q     <= hi_cnt_d;
            lock_cnt_q   <= lock_cnt_d;
            dcs_locked_q <= locked_d;
            int_clk_q    <= int_clk_d;
        end
    end

    // Status bits for the read mux
    assign status = {dcs_locked_q, ps_q == PS_STBY, ps_q == PS_OFF};

    // Power enables, sample strobe and reference selection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_q       <= 1'b0;
            out_drv_oe_q   <= 1'b0;
            ref_on_q       <= 1'b0;
            ref_buf_on_q   <= 1'b0;
            bias_on_q      <= 1'b0;
            ref_internal_q <= 1'b0;
        end else begin
            sample_q       <= div_start;
            out_drv_oe_q   <= (ps_d != PS_OFF);
            ref_on_q       <= (ps_d != PS_OFF);
            ref_buf_on_q   <= (ps_d == PS_RUN);
            bias_on_q      <= (ps_d == PS_RUN);
            ref_internal_q <= !sense_sync_q[1];
        end
    end
endmodule

// *** cdp_pkg.sv ***
// Constants, register map and types for the clock divider and power control
package cdp_pkg;
    // Register bus widths
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [12:0] REG_SYNC_CTRL  = 13'h109; // Divider alignment
    localparam logic [12:0] REG_DIV_RATIO  = 13'h10b; // Divide ratio minus one
    localparam logic [12:0] REG_PWR_MODE   = 13'h008; // Power state request
    localparam logic [12:0] REG_DCS_CTRL   = 13'h009; // Stabilizer enable
    localparam logic [12:0] REG_STATUS     = 13'h00a; // Read-only state

    // Reset values
    localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RATIO_RST = 8'h00; // Divide by one
    localparam logic [7:0] PWR_MODE_RST  = 8'h00; // Normal operation
    localparam logic [7:0] DCS_CTRL_RST  = 8'h01; // Stabilizer on

    // Field positions
    localparam int unsigned SYNC_EN_BIT   = 0; // Alignment enabled
    localparam int unsigned SYNC_ONCE_BIT = 1; // Only first pulse after write
    localparam int unsigned DCS_EN_BIT    = 0;
    localparam int unsigned DIV_LSB       = 0;
    localparam int unsigned DIV_W         = 3; // Ratios 1 to 8
    localparam int unsigned PWR_LSB       = 0;
    localparam int unsigned PWR_W         = 2;
    localparam int unsigned ST_OFF_BIT    = 0;
    localparam int unsigned ST_STBY_BIT   = 1;
    localparam int unsigned ST_LOCK_BIT   = 2;
    localparam int unsigned ST_REFI_BIT   = 3;
    localparam int unsigned ST_ARMED_BIT  = 4;

    // Power mode request codes
    localparam logic [1:0] PWR_REQ_RUN  = 2'h0;
    localparam logic [1:0] PWR_REQ_OFF  = 2'h1;
    localparam logic [1:0] PWR_REQ_STBY = 2'h2;

    // Timing
    localparam int unsigned CLK_PERIOD_NS     = 50;   // core_clk, 20 MHz
    localparam int unsigned DCS_RELOCK_MIN_NS = 1500; // Least relock wait
    localparam int unsigned DCS_RELOCK_CYC    =
        (DCS_RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DCS_SLOW_MHZ      = 20;   // Loop lower limit

    // Power states
    typedef enum logic [2:0] {
        PS_RUN  = 3'b001,
        PS_STBY = 3'b010,
        PS_OFF  = 3'b100
    } cdp_pwr_state_t;
endpackage

// *** cdp_div_cnt.sv ***
// Realignable divider counter for the incoming sample clock
`timescale 1ns/10ps
module cdp_div_cnt #(
    parameter int unsigned W = 3
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic         advance,   // Sample clock rising edge seen
    input  wire logic         realign,   // Accepted alignment pulse
    input  wire logic [W-1:0] ratio_m1,  // Divide ratio minus one
    output logic              start,     // This edge opens a divided period
    output logic [W-1:0]      cnt_q      // Position inside the period
);
    logic [W-1:0] cnt_d;
    logic [W-1:0] base;

    // Next count; realignment forces the initial state
    always_comb begin
        base  = realign ? '0 : cnt_q;
        start = advance && (base == '0);
        cnt_d = base;
        if (advance) begin
            cnt_d = (base == ratio_m1) ? '0 : base + W'(1);
        end
    end

    // Count register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

// *** cdp_clk_pwr_sva.sv ***
// Checker on the ports of the clock and power control block
`timescale 1ns/10ps
module cdp_clk_pwr_sva
    import cdp_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic              sample_clk_in,
    input wire logic              sync_in,
    input wire logic              power_down_pin,
    input wire logic              sense_at_supply,
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata_q,
    input wire logic              int_clk_q,
    input wire logic              sample_q,
    input wire logic              out_drv_oe_q,
    input wire logic              ref_on_q,
    input wire logic              ref_buf_on_q,
    input wire logic              bias_on_q,
    input wire logic              ref_internal_q,
    input wire logic              dcs_locked_q
);
    // One clock domain for every check
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Pin held high turns drivers and power enables off
    a_pin_forces_off: assert property (
        power_down_pin [*4] |=> !out_drv_oe_q && !ref_on_q && !bias_on_q)
        else $error("power-down pin did not switch the outputs off");
    // No internal clock while the reference is off
    a_off_quiet: assert property (
        !ref_on_q [*2] |-> !int_clk_q && !sample_q)
        else $error("internal clock runs while powered down");
    // Standby and off never sample
    a_stby_no_samp: assert property (
        !bias_on_q [*2] |-> !sample_q)
        else $error("sample pulse while not running");
    // Only run, standby and off enable patterns occur
    a_state_legal: assert property (
        ref_buf_on_q == bias_on_q && out_drv_oe_q == ref_on_q
        && (ref_on_q || !bias_on_q))
        else $error("illegal mix of power enables");
    // Sample strobe launches with each internal clock rise
    a_samp_follows: assert property (
        $rose(int_clk_q) |-> sample_q)
        else $error("internal clock rise without sample strobe");
    // Strobe only while the internal clock is high, one cycle long
    a_samp_cause: assert property (
        sample_q |-> int_clk_q && !$past(sample_q))
        else $error("sample strobe without internal clock high");
    // Sense at supply deselects the internal reference
    a_ref_ext: assert property (
        sense_at_supply [*4] |-> !ref_internal_q)
        else $error("internal reference kept with sense at supply");
    // Grounded sense selects the internal reference while powered
    a_ref_int: assert property (
        (!sense_at_supply && ref_on_q) [*4] |-> ref_internal_q)
        else $error("internal reference not selected with sense low");
endmodule
bind cdp_clk_pwr cdp_clk_pwr_sva i_sva (.*);

// *** cdp_host_model.sv ***
// Host-side model: sample clock source and alignment pulse driver
`timescale 1ns/10ps
module cdp_host_model (
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] hi_cyc,        // High time in core cycles
    input  wire logic [3:0] lo_cyc,        // Low time in core cycles
    input  wire logic       sync_req,      // Request one alignment pulse
    output logic            sample_clk_in, // Free-running sample clock
    output logic            sync_in        // Alignment pin
);
    logic [3:0] ph_q; // Cycles left in the current clock phase
    logic [2:0] sp_q; // Cycles left in the alignment pulse
    // Free-running source; new hi/lo values change its frequency
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_q          <= 4'h1;
            sample_clk_in <= 1'b0;
        end else if (ph_q <= 4'h1) begin
            sample_clk_in <= ~sample_clk_in;
            ph_q          <= sample_clk_in ? lo_cyc : hi_cyc;
        end else begin
            ph_q <= ph_q - 4'h1;
        end
    end
    // Pulse held four cycles so every sharing device catches it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sp_q    <= 3'h0;
            sync_in <= 1'b0;
        end else begin
            sp_q    <= sync_req ? 3'h4 : sp_q - {2'h0, sp_q != 3'h0};
            sync_in <= sync_req || sp_q > 3'h1;
        end
    end
endmodule

// *** tb_cdp_clk_pwr.sv ***
// Self-checking bench for the clock divider and power control block
`timescale 1ns/10ps
module tb_cdp_clk_pwr;
    import cdp_pkg::*;
    logic              core_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic              power_down_pin = 1'b0;
    logic              sense_at_supply = 1'b0; // Always driven
    logic              reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic              sync_req = 1'b0, snap_req = 1'b0, rd_d = 1'b0;
    logic              sy_d = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [3:0]        hi_cyc = 4'h3, lo_cyc = 4'h3;
    logic              sample_clk_in, sync_in, int_clk_q, sample_q;
    logic              out_drv_oe_q, ref_on_q, ref_buf_on_q, bias_on_q;
    logic              ref_internal_q, dcs_locked_q;
    logic [DATA_W-1:0] reg_rdata_q;
    logic [15:0]       rdq[$];          // Expected read data and mask
    logic [3:0]        snq[$];          // Expected power enables
    logic              latq[$];         // Realign expected per pulse
    int                gapq[$], hiq[$]; // Expected gap and high time
    int                miscompares = 0, comparisons = 0;
    int                cyc = 0, last_s = 0, hi_n = 0, s_cnt = 0;
    // Alignment modes: off, every pulse, first pulse after write
    logic [7:0]        sync_tab[3] = '{8'h00, 8'h01, 8'h03};
    logic [1:0]        sync_exp[3] = '{2'b00, 2'b11, 2'b01};
    // Stabilizer cases: ratio field, enable, internal high time
    logic [7:0]        dcs_div[3] = '{8'h00, 8'h01, 8'h00};
    logic [7:0]        dcs_en[3] = '{8'h01, 8'h01, 8'h00};
    int                dcs_hi[3] = '{3, 6, 2};
    // Power cases: pin, mode request, {oe, ref, buffer, bias}
    logic [6:0]        pw_tab[6] = '{{1'b1, PWR_REQ_RUN, 4'h0},
        {1'b0, PWR_REQ_RUN, 4'hf}, {1'b0, PWR_REQ_OFF, 4'h0},
        {1'b0, PWR_REQ_STBY, 4'hc}, {1'b1, PWR_REQ_STBY, 4'h0},
        {1'b0, PWR_REQ_RUN, 4'hf}};

    cdp_clk_pwr #(.SLOW_LIMIT(20)) i_dut (.*);
    cdp_host_model i_host (.*);

    // 20 MHz core clock
    always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    task automatic fail(input string m);
        miscompares++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    // Compare read data under a mask
    task automatic chk_rd(input logic [7:0] g, input logic [15:0] e);
        comparisons++;
        if ((g & e[7:0]) !== (e[15:8] & e[7:0])) fail("read data");
    endtask
    // Compare a snapshot of the power enables
    task automatic chk_v(input logic [3:0] g, input logic [3:0] e);
        comparisons++;
        if (g !== e) fail("power enables");
    endtask
    // Compare a count measured by the bench
    task automatic chk_n(input int g, input int e);
        comparisons++;
        if (g != e) fail("cycle count");
    endtask
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Register write, taken at the next edge
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask
    // Register read; expectation noted before the strobe
    task automatic rd(input logic [12:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        rdq.push_back({e, m});
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
    endtask
    // Wait for n sample strobes, bounded
    task automatic wait_s(input int n);
        for (int k = 0; k < 2000 && n > 0; k++) begin
            @(posedge core_clk);
            if (sample_q === 1'b1) n--;
        end
        if (n > 0) fail("sample strobe missing");
    endtask

    // Monitor: takes the oldest note whenever a result appears
    always @(posedge core_clk) begin
        cyc++;
        rd_d <= reg_rd_en;
        sy_d <= sync_in;
        s_cnt = (sync_in && !sy_d) ? 0 : s_cnt + 1;
        if (rd_d) chk_rd(reg_rdata_q, rdq.pop_front());
        if (snap_req) chk_v({out_drv_oe_q, ref_on_q, ref_buf_on_q,
            bias_on_q}, snq.pop_front());
        if (sample_q === 1'b1) begin
            if (gapq.size() > 0) chk_n(cyc - last_s, gapq.pop_front());
            if (latq.size() > 0) chk_n(int'(s_cnt <= 20),
                int'(latq.pop_front()));
            last_s = cyc;
        end
        if (int_clk_q === 1'b1) begin
            hi_n++;
        end else begin
            if (hi_n > 0 && hiq.size() > 0)
                chk_n(hi_n, hiq.pop_front());
            hi_n = 0;
        end
    end

    // Watchdog well beyond the expected run
    initial begin
        #(CLK_PERIOD_NS * 30000);
        fail("watchdog expired");
        complete_run();
    end

    initial begin
        void'($urandom(32'h9f3a));
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, unmapped read, read-only status
        rd(REG_SYNC_CTRL, SYNC_CTRL_RST, 8'hff);
        rd(REG_DIV_RATIO, DIV_RATIO_RST, 8'hff);
        rd(REG_PWR_MODE, PWR_MODE_RST, 8'hff);
        rd(REG_DCS_CTRL, DCS_CTRL_RST, 8'hff);
        rd(13'h1ff, 8'h00, 8'hff);
        wr(REG_STATUS, 8'hff);
        rd(REG_STATUS, 8'h08, 8'h1b);
        $display("test reset values done");
        wait_s(3);
        gapq.push_back(6);
        for (int n = 1; n <= 8; n++) begin
            wr(REG_DIV_RATIO, 8'(n - 1));
            wait_s(3);
            gapq.push_back(6 * n);
            wait_s(2);
        end
        $display("test divide ratios done");
        // Pulses at random spots in a divide-by-eight period
        for (int t = 0; t < 3; t++) begin
            wr(REG_SYNC_CTRL, sync_tab[t]);
            if (t == 2) rd(REG_STATUS, 8'h10, 8'h10);
            for (int p = 0; p < 2; p++) begin
                wait_s(1);
                repeat (8 + $urandom_range(0, 10)) @(posedge core_clk);
                sync_req <= 1'b1;
                @(posedge core_clk);
                sync_req <= 1'b0;
                @(posedge core_clk);
                latq.push_back(sync_exp[t][p]);
                wait_s(1);
            end
        end
        rd(REG_STATUS, 8'h00, 8'h10);
        wr(REG_SYNC_CTRL, 8'h00);
        $display("test alignment done");
        // Uneven input duty cycle, period six
        hi_cyc <= 4'h2;
        lo_cyc <= 4'h4;
        for (int t = 0; t < 3; t++) begin
            wr(REG_DIV_RATIO, dcs_div[t]);
            wr(REG_DCS_CTRL, dcs_en[t]);
            repeat (120) @(posedge core_clk);
            hiq.push_back(dcs_hi[t]);
            wait_s(2);
        end
        // Frequency change drops lock, relock within bound
        wr(REG_DCS_CTRL, 8'h01);
        hi_cyc <= 4'h4;
        lo_cyc <= 4'h4;
        repeat (28) @(posedge core_clk);
        rd(REG_STATUS, 8'h00, 8'h04);
        for (int k = 0; k < 100 && dcs_locked_q !== 1'b1; k++) begin
            @(posedge core_clk);
        end
        rd(REG_STATUS, 8'h04, 8'h04);
        // Too slow for the loop: never locks
        hi_cyc <= 4'hc;
        lo_cyc <= 4'hc;
        repeat (200) @(posedge core_clk);
        rd(REG_STATUS, 8'h00, 8'h04);
        hi_cyc <= 4'h3;
        lo_cyc <= 4'h3;
        $display("test stabilizer done");
        for (int t = 0; t < 2; t++) begin
            sense_at_supply <= t[0];
            repeat (6) @(posedge core_clk);
            rd(REG_STATUS, {4'h0, ~t[0], 3'h0}, 8'h08);
        end
        // Power states by pin and by register
        foreach (pw_tab[t]) begin
            wr(REG_PWR_MODE, {6'h00, pw_tab[t][5:4]});
            power_down_pin <= pw_tab[t][6];
            repeat (8) @(posedge core_clk);
            snq.push_back(pw_tab[t][3:0]);
            snap_req <= 1'b1;
            @(posedge core_clk);
            snap_req <= 1'b0;
        end
        wait_s(3);
        gapq.push_back(6);
        wait_s(2);
        $display("test power states done");
        complete_run();
    end
endmodule
